// [shared/limit_regs_params.svh]
// Purpose: offsets, field positions, reset values and limits of the limit register bank
// Assumes: command codes arrive already decoded from the management bus engine
// Notes: definitions only
//
// Operation
// - upper limit is 2mV/LSB, capped at 5.5V, resets to 0x0226.
// - setpoint above upper limit takes the limit, sets summary and warning, alerts.
// - setpoint below lower limit takes the limit, sets summary and warning, alerts.
// - upper margin is 2mV/LSB, bits 15:12 read-only, resets to 0x0226.
// - lower margin is 2mV/LSB and resets to 0x0190.
// - divider ratio is 0.001/LSB and resets to 0x028c.
// - lower limit is 2mV/LSB, floored at 0.5V, resets to 0x0170.
// - start threshold is six bits, 250mV/LSB, 4V to 15V, upper bits read-only.
// - start threshold resets to 0x000c.
// - conversion starts only when input reaches start threshold and start conditions hold.
// - feedback reference is output setpoint times divider ratio.
// - running conversion stops when input falls to the stop threshold.
`ifndef LIMIT_REGS_PARAMS_SVH
`define LIMIT_REGS_PARAMS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define OFS_CLEAR_STATUS 8'h03
`define OFS_SETPOINT 8'h21
`define OFS_UPPER_LIMIT 8'h24
`define OFS_MARGIN_HIGH 8'h25
`define OFS_MARGIN_LOW 8'h26
`define OFS_DIV_RATIO 8'h29
`define OFS_LOWER_LIMIT 8'h2b
`define OFS_START_THR 8'h35
`define OFS_STOP_THR 8'h36
`define OFS_STATUS_WORD 8'h79
`define OFS_OUT_STATUS 8'h7a

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define MV_FIELD_W 12
`define THR_FIELD_W 6
`define SUMMARY_BIT_POS 15
`define WARN_BIT_POS 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_SETPOINT 12'h1cc
`define RST_UPPER_LIMIT 12'h226
`define RST_MARGIN_HIGH 12'h226
`define RST_MARGIN_LOW 12'h190
`define RST_DIV_RATIO 12'h28c
`define RST_LOWER_LIMIT 12'h170
`define RST_START_THR 6'h0c
`define RST_STOP_THR 6'h0b

// ----------------------------------------------------------------
// accepted ranges
// ----------------------------------------------------------------
`define UPPER_LIMIT_MAX 12'habe
`define LOWER_LIMIT_MIN 12'h0fa
`define START_THR_MIN 6'h10
`define START_THR_MAX 6'h3c
`define STOP_THR_MIN 6'h0b
`define STOP_THR_MAX 6'h3b

`endif

// [shared/limit_regs_pkg.sv]
// Purpose: shared types of the limit register bank
// Assumes: nothing
// Notes: constants live in the params header
`default_nettype none
package limit_regs_pkg;
    typedef logic [11:0] mv_type;
    typedef logic [5:0] thr_type;
    typedef logic [15:0] word_type;
    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN = 1'b1
    } conv_state_type;
endpackage
`default_nettype wire

// [shared/limit_ctl_if.sv]
// Purpose: links the register bank to its clamp and start gate
// Assumes: single clock
// Notes: clamp side is combinational
`timescale 1ns/1ps
`default_nettype none
interface limit_ctl_if;
    import limit_regs_pkg::*;
    mv_type req;
    mv_type upper;
    mv_type lower;
    mv_type result;
    logic above;
    logic below;
    thr_type start_thr;
    thr_type stop_thr;
    logic [7:0] vin;
    logic start_ok;
    logic convert;
    modport bank(output req, upper, lower, start_thr, stop_thr, vin, start_ok,
                 input result, above, below, convert);
    modport clamp(input req, upper, lower, output result, above, below);
    modport gate(input start_thr, stop_thr, vin, start_ok, output convert);
endinterface
`default_nettype wire

// [logic/setpoint_clamp.sv]
// Purpose: bounds a requested output setpoint by the two limits
// Assumes: limits hold upper >= lower
// Notes: upper limit wins if the limits cross
`timescale 1ns/1ps
`default_nettype none
module setpoint_clamp
    import limit_regs_pkg::*;
(
    limit_ctl_if.clamp ctl
);
    always_comb begin
        ctl.above = ctl.req > ctl.upper;
        ctl.below = ctl.req < ctl.lower;
        if (ctl.below) begin
            ctl.result = ctl.lower;
        end else begin
            ctl.result = ctl.req;
        end
        // the upper limit is the safeguard, so it is applied last
        if (ctl.result > ctl.upper) begin
            ctl.result = ctl.upper;
        end
    end
endmodule
`default_nettype wire

// [logic/conv_start_gate.sv]
// Purpose: start and stop decision from input voltage against two thresholds
// Assumes: vin code is 250mV per LSB, synchronous to the clock
// Notes: hysteresis depends on the host keeping start above stop
`timescale 1ns/1ps
`default_nettype none
module conv_start_gate
    import limit_regs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    limit_ctl_if.gate ctl
);
    conv_state_type state_q;
    conv_state_type state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CONV_IDLE: begin
                if (ctl.start_ok && ctl.vin >= {2'h0, ctl.start_thr}) begin
                    state_d = CONV_RUN;
                end
            end
            CONV_RUN: begin
                // a dropped start condition also stops, so enable release is honoured
                if (!ctl.start_ok || ctl.vin <= {2'h0, ctl.stop_thr}) begin
                    state_d = CONV_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= CONV_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign ctl.convert = (state_q == CONV_RUN);
endmodule
`default_nettype wire

// [logic/limit_reg_bank.sv]
// Purpose: output limit, margin, divider ratio and input threshold registers
// Assumes: a bus engine hands over decoded command codes and 16-bit words
// Notes: unknown codes are refused with a one-cycle flag
`timescale 1ns/1ps
`default_nettype none
`include "limit_regs_params.svh"
module limit_reg_bank
    import limit_regs_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // command port
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_STB,
    input wire logic [15:0] WR_DATA,
    input wire logic RD_STB,
    output logic [15:0] RD_DATA,
    output logic RD_VALID,
    output logic CMD_UNSUP,
    // host notification
    output logic ALERT_N,
    // converter side
    input wire logic [7:0] VIN_CODE,
    input wire logic START_OK,
    output logic CONVERT_EN,
    output logic [11:0] SETPOINT,
    output logic [23:0] FB_REF
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    mv_type setpoint_q, setpoint_d;
    mv_type upper_q, upper_d;
    mv_type margin_hi_q, margin_hi_d;
    mv_type margin_lo_q, margin_lo_d;
    mv_type ratio_q, ratio_d;
    mv_type lower_q, lower_d;
    thr_type start_q, start_d;
    thr_type stop_q, stop_d;
    logic summary_q, summary_d;
    logic warn_q, warn_d;
    logic alert_n_q, alert_n_d;
    word_type rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic unsup_q, unsup_d;
    logic convert_q;
    logic [23:0] fbref_q, fbref_d;

    mv_type wr_mv;
    thr_type wr_thr;
    logic known;
    logic clamp_hit;

    limit_ctl_if ctl();

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    setpoint_clamp u_clamp (
        .ctl(ctl.clamp)
    );

    conv_start_gate u_gate (
        .clk(REF_CLK),
        .rst(RESET),
        .ctl(ctl.gate)
    );

    // upper bits of a write are dropped here
    assign wr_mv = WR_DATA[11:0];
    assign wr_thr = WR_DATA[5:0];
    assign ctl.req = wr_mv;
    assign ctl.upper = upper_q;
    assign ctl.lower = lower_q;
    assign ctl.start_thr = start_q;
    assign ctl.stop_thr = stop_q;
    assign ctl.vin = VIN_CODE;
    assign ctl.start_ok = START_OK;

    always_comb begin
        unique case (CMD_CODE)
            `OFS_CLEAR_STATUS, `OFS_SETPOINT, `OFS_UPPER_LIMIT, `OFS_MARGIN_HIGH,
            `OFS_MARGIN_LOW, `OFS_DIV_RATIO, `OFS_LOWER_LIMIT, `OFS_START_THR,
            `OFS_STOP_THR, `OFS_STATUS_WORD, `OFS_OUT_STATUS: begin
                known = 1'b1;
            end
            default: begin
                known = 1'b0;
            end
        endcase
    end

    assign clamp_hit = WR_STB && CMD_CODE == `OFS_SETPOINT && (ctl.above || ctl.below);

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_comb begin
        setpoint_d = setpoint_q;
        upper_d = upper_q;
        margin_hi_d = margin_hi_q;
        margin_lo_d = margin_lo_q;
        ratio_d = ratio_q;
        lower_d = lower_q;
        start_d = start_q;
        stop_d = stop_q;
        if (WR_STB) begin
            unique case (CMD_CODE)
                `OFS_SETPOINT: begin
                    setpoint_d = ctl.result;
                end
                `OFS_UPPER_LIMIT: begin
                    // larger requests saturate rather than being lost
                    if (wr_mv > `UPPER_LIMIT_MAX) begin
                        upper_d = `UPPER_LIMIT_MAX;
                    end else begin
                        upper_d = wr_mv;
                    end
                end
                `OFS_MARGIN_HIGH: begin
                    margin_hi_d = wr_mv;
                end
                `OFS_MARGIN_LOW: begin
                    margin_lo_d = wr_mv;
                end
                `OFS_DIV_RATIO: begin
                    ratio_d = wr_mv;
                end
                `OFS_LOWER_LIMIT: begin
                    if (wr_mv < `LOWER_LIMIT_MIN) begin
                        lower_d = `LOWER_LIMIT_MIN;
                    end else begin
                        lower_d = wr_mv;
                    end
                end
                `OFS_START_THR: begin
                    if (wr_thr < `START_THR_MIN) begin
                        start_d = `START_THR_MIN;
                    end else if (wr_thr > `START_THR_MAX) begin
                        start_d = `START_THR_MAX;
                    end else begin
                        start_d = wr_thr;
                    end
                end
                `OFS_STOP_THR: begin
                    if (wr_thr < `STOP_THR_MIN) begin
                        stop_d = `STOP_THR_MIN;
                    end else if (wr_thr > `STOP_THR_MAX) begin
                        stop_d = `STOP_THR_MAX;
                    end else begin
                        stop_d = wr_thr;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // status and notification
    // ----------------------------------------------------------------
    always_comb begin
        summary_d = summary_q;
        warn_d = warn_q;
        if (WR_STB && CMD_CODE == `OFS_CLEAR_STATUS) begin
            summary_d = 1'b0;
            warn_d = 1'b0;
        end
        if (WR_STB && CMD_CODE == `OFS_OUT_STATUS && WR_DATA[`WARN_BIT_POS]) begin
            warn_d = 1'b0;
        end
        // a clamp in the same cycle as a clear keeps the flags set
        if (clamp_hit) begin
            summary_d = 1'b1;
            warn_d = 1'b1;
        end
        alert_n_d = !(summary_d || warn_d);
    end

    // ----------------------------------------------------------------
    // read path and feedback reference
    // ----------------------------------------------------------------
    always_comb begin
        rd_data_d = rd_data_q;
        rd_valid_d = RD_STB && known;
        unsup_d = (RD_STB || WR_STB) && !known;
        if (RD_STB) begin
            // read-only bits above each field return zero
            unique case (CMD_CODE)
                `OFS_SETPOINT: rd_data_d = {4'h0, setpoint_q};
                `OFS_UPPER_LIMIT: rd_data_d = {4'h0, upper_q};
                `OFS_MARGIN_HIGH: rd_data_d = {4'h0, margin_hi_q};
                `OFS_MARGIN_LOW: rd_data_d = {4'h0, margin_lo_q};
                `OFS_DIV_RATIO: rd_data_d = {4'h0, ratio_q};
                `OFS_LOWER_LIMIT: rd_data_d = {4'h0, lower_q};
                `OFS_START_THR: rd_data_d = {10'h000, start_q};
                `OFS_STOP_THR: rd_data_d = {10'h000, stop_q};
                `OFS_STATUS_WORD: begin
                    rd_data_d = 16'h0000;
                    rd_data_d[`SUMMARY_BIT_POS] = summary_q;
                end
                `OFS_OUT_STATUS: begin
                    rd_data_d = 16'h0000;
                    rd_data_d[`WARN_BIT_POS] = warn_q;
                end
                default: rd_data_d = 16'h0000;
            endcase
        end
        fbref_d = 24'(setpoint_q) * 24'(ratio_q);
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            setpoint_q <= `RST_SETPOINT;
            upper_q <= `RST_UPPER_LIMIT;
            margin_hi_q <= `RST_MARGIN_HIGH;
            margin_lo_q <= `RST_MARGIN_LOW;
            ratio_q <= `RST_DIV_RATIO;
            lower_q <= `RST_LOWER_LIMIT;
            start_q <= `RST_START_THR;
            stop_q <= `RST_STOP_THR;
            summary_q <= 1'b0;
            warn_q <= 1'b0;
            alert_n_q <= 1'b1;
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            unsup_q <= 1'b0;
            convert_q <= 1'b0;
            fbref_q <= 24'h000000;
        end else begin
            setpoint_q <= setpoint_d;
            upper_q <= upper_d;
            margin_hi_q <= margin_hi_d;
            margin_lo_q <= margin_lo_d;
            ratio_q <= ratio_d;
            lower_q <= lower_d;
            start_q <= start_d;
            stop_q <= stop_d;
            summary_q <= summary_d;
            warn_q <= warn_d;
            alert_n_q <= alert_n_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            unsup_q <= unsup_d;
            convert_q <= ctl.convert;
            fbref_q <= fbref_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign RD_DATA = rd_data_q;
    assign RD_VALID = rd_valid_q;
    assign CMD_UNSUP = unsup_q;
    assign ALERT_N = alert_n_q;
    assign CONVERT_EN = convert_q;
    assign SETPOINT = setpoint_q;
    assign FB_REF = fbref_q;
endmodule
`default_nettype wire

// [tb/limit_bank_monitor.sv]
// Purpose: port-level checks of the limit register bank
// Assumes: limit shadows saturate the way the bank does
// Notes: bound to every limit_reg_bank instance
`timescale 1ns/1ps
`default_nettype none
module limit_bank_monitor (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // command port
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_STB,
    input wire logic [15:0] WR_DATA,
    input wire logic RD_STB,
    input wire logic RD_VALID,
    input wire logic CMD_UNSUP,
    input wire logic ALERT_N,
    // converter side
    input wire logic [7:0] VIN_CODE,
    input wire logic START_OK,
    input wire logic CONVERT_EN,
    input wire logic [11:0] SETPOINT,
    input wire logic [23:0] FB_REF
);
    // ----
    // shadows of the limits, fed only from the write port
    // ----
    logic [11:0] up_q, up_d, lo_q, lo_d, ra_q, ra_d;
    logic [5:0] st_q, st_d, sp_q, sp_d;
    logic [1:0] live_q, live_d;
    wire [11:0] wd = WR_DATA[11:0];
    wire [5:0] w6 = WR_DATA[5:0];
    wire wsp = WR_STB && CMD_CODE == 8'h21;
    wire wclr = WR_STB && CMD_CODE == 8'h03;
    always_comb begin
        up_d = up_q;
        lo_d = lo_q;
        ra_d = ra_q;
        st_d = st_q;
        sp_d = sp_q;
        live_d = live_q + 2'(live_q != 2'h2);
        if (WR_STB && CMD_CODE == 8'h24) up_d = (wd > 12'habe) ? 12'habe : wd;
        if (WR_STB && CMD_CODE == 8'h2b) lo_d = (wd < 12'h0fa) ? 12'h0fa : wd;
        if (WR_STB && CMD_CODE == 8'h29) ra_d = wd;
        if (WR_STB && CMD_CODE == 8'h35) st_d = (w6 < 6'h10) ? 6'h10 : (w6 > 6'h3c) ? 6'h3c : w6;
        if (WR_STB && CMD_CODE == 8'h36) sp_d = (w6 < 6'h0b) ? 6'h0b : (w6 > 6'h3b) ? 6'h3b : w6;
    end
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            up_q <= 12'h226;
            lo_q <= 12'h170;
            ra_q <= 12'h28c;
            st_q <= 6'h0c;
            sp_q <= 6'h0b;
            live_q <= 2'h0;
        end else begin
            up_q <= up_d;
            lo_q <= lo_d;
            ra_q <= ra_d;
            st_q <= st_d;
            sp_q <= sp_d;
            live_q <= live_d;
        end
    end
    // ----
    // assertions
    // ----
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    sequence s_high;
        wsp && wd > up_q;
    endsequence
    sequence s_low;
        wsp && wd < lo_q && lo_q <= up_q;
    endsequence
    a_clamp_high: assert property (s_high |=> SETPOINT == $past(up_q) && !ALERT_N)
        else $error("setpoint not held at upper limit");
    a_clamp_low: assert property (s_low |=> SETPOINT == $past(lo_q) && !ALERT_N)
        else $error("setpoint not held at lower limit");
    a_setpoint_pass: assert property (wsp && wd >= lo_q && wd <= up_q |=>
        SETPOINT == $past(wd))
        else $error("in-range setpoint altered");
    // live_q waits out the edge at which the product is still zero
    a_fb_product: assert property (live_q == 2'h2 |->
        FB_REF == 24'($past(SETPOINT)) * 24'($past(ra_q)))
        else $error("feedback reference not setpoint times ratio");
    a_alert_keep: assert property (!ALERT_N && !wclr |=> !ALERT_N)
        else $error("alert dropped without clear");
    a_alert_clear: assert property (wclr |=> ALERT_N)
        else $error("alert not released by clear");
    a_alert_cause: assert property ($fell(ALERT_N) |-> $past(wsp))
        else $error("alert without setpoint write");
    a_read_answer: assert property (RD_STB |=> RD_VALID != CMD_UNSUP)
        else $error("read got no single answer");
    a_conv_start: assert property ($rose(CONVERT_EN) |-> $past(START_OK, 2)
        && $past(VIN_CODE, 2) >= $past(st_q, 2))
        else $error("conversion started below threshold");
    a_conv_stop: assert property ($fell(CONVERT_EN) && !$past(RESET) |->
        !$past(START_OK, 2) || $past(VIN_CODE, 2) <= $past(sp_q, 2))
        else $error("conversion stopped above threshold");
endmodule
bind limit_reg_bank limit_bank_monitor limit_bank_monitor_inst (.REF_CLK, .RESET, .CMD_CODE,
    .WR_STB, .WR_DATA, .RD_STB, .RD_VALID, .CMD_UNSUP, .ALERT_N, .VIN_CODE, .START_OK,
    .CONVERT_EN, .SETPOINT, .FB_REF);
`default_nettype wire

// [tb/host_model.sv]
// Purpose: management host issuing one command word per access
// Assumes: answer arrives one cycle after the strobe edge
// Notes: released code and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock
    input wire logic REF_CLK,
    // command port
    output logic [7:0] CMD_CODE,
    output logic WR_STB,
    output logic [15:0] WR_DATA,
    output logic RD_STB,
    input wire logic [15:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic CMD_UNSUP
);
    initial begin
        CMD_CODE = 8'h00;
        WR_STB = 1'b0;
        WR_DATA = 16'h0000;
        RD_STB = 1'b0;
    end
    // ----
    // one access; gap idles first so slow hosts are covered too
    // ----
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input int gap,
                        output logic [15:0] q, output logic v, output logic u);
        repeat (gap) @(posedge REF_CLK);
        @(posedge REF_CLK);
        CMD_CODE <= c;
        WR_DATA <= d;
        WR_STB <= w;
        RD_STB <= !w;
        @(posedge REF_CLK);
        WR_STB <= 1'b0;
        RD_STB <= 1'b0;
        CMD_CODE <= ~c;
        WR_DATA <= ~d;
        #1;
        q = RD_DATA;
        v = RD_VALID;
        u = CMD_UNSUP;
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench of the limit register bank
// Assumes: expectations mirror stored values from the write history
// Notes: limits that cross give the upper limit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import limit_regs_pkg::*;
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [7:0] CMD_CODE, VIN_CODE, c;
    logic WR_STB, RD_STB, RD_VALID, CMD_UNSUP, ALERT_N, START_OK, CONVERT_EN, v, u;
    logic [15:0] WR_DATA, RD_DATA, q, d;
    logic [11:0] SETPOINT;
    logic [23:0] FB_REF;
    logic [11:0] m [256];
    logic [7:0] codes [8] = '{8'h21, 8'h24, 8'h25, 8'h26, 8'h29, 8'h2b, 8'h35, 8'h36};
    logic [11:0] rstv [8] = '{12'h1cc, 12'h226, 12'h226, 12'h190,
        12'h28c, 12'h170, 12'h00c, 12'h00b};
    logic [7:0] wc [8] = '{8'h24, 8'h25, 8'h26, 8'h29, 8'h2b, 8'h35, 8'h35, 8'h36};
    logic [15:0] wv [8] = '{16'hffff, 16'hffff, 16'hf123, 16'hffff,
        16'h0000, 16'hffff, 16'h0000, 16'h0000};
    logic [7:0] vin_t [6] = '{8'h1f, 8'h20, 8'h19, 8'h18, 8'h20, 8'h20};
    logic [5:0] ok_t = 6'b011111;
    logic [5:0] ex_t = 6'b010110;
    int fails = 0, check_count = 0, seed = 21, k;
    always #4 REF_CLK = ~REF_CLK;
    limit_reg_bank limit_reg_bank_inst (.REF_CLK, .RESET, .CMD_CODE, .WR_STB, .WR_DATA, .RD_STB,
        .RD_DATA, .RD_VALID, .CMD_UNSUP, .ALERT_N, .VIN_CODE, .START_OK, .CONVERT_EN, .SETPOINT,
        .FB_REF);
    host_model host_model_inst (.REF_CLK, .CMD_CODE, .WR_STB, .WR_DATA, .RD_STB, .RD_DATA,
        .RD_VALID, .CMD_UNSUP);
    // ----
    // compare and access helpers
    // ----
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic rq(input logic [7:0] a);
        host_model_inst.xfer(1'b0, a, 16'h0000, 0, q, v, u);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        rq(a);
        chk("read data", e, q);
        chk_bit("read valid", 1'b1, v);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        host_model_inst.xfer(1'b1, a, w, $unsigned($random(seed)) % 3, q, v, u);
    endtask
    // saturation of limits; setpoint bounded, upper limit last so it wins
    function automatic logic [11:0] stored(input logic [7:0] a, input logic [15:0] w);
        logic [11:0] t;
        t = (w[11:0] < m[8'h2b]) ? m[8'h2b] : w[11:0];
        case (a)
            8'h24: return (w[11:0] > 12'habe) ? 12'habe : w[11:0];
            8'h2b: return (w[11:0] < 12'h0fa) ? 12'h0fa : w[11:0];
            8'h35: return (w[5:0] < 6'h10) ? 12'h010 : (w[5:0] > 6'h3c) ? 12'h03c : {6'h0, w[5:0]};
            8'h36: return (w[5:0] < 6'h0b) ? 12'h00b : (w[5:0] > 6'h3b) ? 12'h03b : {6'h0, w[5:0]};
            8'h21: return (t > m[8'h24]) ? m[8'h24] : t;
            default: return w[11:0];
        endcase
    endfunction
    task automatic sp_case(input logic [15:0] w);
        logic [11:0] e;
        logic hit;
        e = stored(8'h21, w);
        hit = w[11:0] < m[8'h2b] || w[11:0] > m[8'h24];
        wr(8'h21, w);
        m[8'h21] = e;
        chk("setpoint", e, SETPOINT);
        chk_bit("alert", !hit, ALERT_N);
        @(posedge REF_CLK);
        #1;
        chk("fb ref", 24'(e) * 24'(m[8'h29]), FB_REF);
        if (hit) begin
            rq(8'h79);
            chk_bit("summary", 1'b1, q[15]);
            rq(8'h7a);
            chk_bit("warning", 1'b1, q[3]);
            wr(8'h7a, 16'h0008);
            rq(8'h7a);
            chk_bit("warning", 1'b0, q[3]);
            chk_bit("alert", 1'b0, ALERT_N);
            wr(8'h03, 16'h0000);
            chk_bit("alert", 1'b1, ALERT_N);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge REF_CLK);
        fails++;
        finish_test();
    end
    // ----
    // main sequence
    // ----
    initial begin
        VIN_CODE = 8'h00;
        START_OK = 1'b0;
        repeat (16) @(posedge REF_CLK);
        RESET <= 1'b0;
        for (k = 0; k < 8; k++) begin
            m[codes[k]] = rstv[k];
            rd(codes[k], {4'h0, rstv[k]});
        end
        rq(8'h00);
        chk_bit("unsupported read", 1'b1, u);
        chk("unsupported data", 24'h0, q);
        wr(8'h00, 16'h1234);
        chk_bit("unsupported write", 1'b1, u);
        for (k = 0; k < 8; k++) begin
            wr(wc[k], wv[k]);
            m[wc[k]] = stored(wc[k], wv[k]);
            rd(wc[k], {4'h0, m[wc[k]]});
        end
        for (k = 0; k < 40; k++) begin
            c = codes[$unsigned($random(seed)) % 8];
            d = 16'($random(seed));
            if (c == 8'h21) begin
                sp_case(d);
            end else begin
                wr(c, d);
                m[c] = stored(c, d);
                rd(c, {4'h0, m[c]});
            end
        end
        wr(8'h24, 16'h0300);
        m[8'h24] = 12'h300;
        wr(8'h2b, 16'h0100);
        m[8'h2b] = 12'h100;
        wr(8'h29, 16'h028c);
        m[8'h29] = 12'h28c;
        sp_case(16'h0fff);
        sp_case(16'h0050);
        sp_case(16'h0300);
        wr(8'h35, 16'h0020);
        wr(8'h36, 16'h0018);
        for (k = 0; k < 6; k++) begin
            @(posedge REF_CLK);
            VIN_CODE <= vin_t[k];
            START_OK <= ok_t[k];
            repeat (3) @(posedge REF_CLK);
            #1;
            chk_bit("convert", ex_t[k], CONVERT_EN);
        end
        @(posedge REF_CLK);
        RESET <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        RESET <= 1'b0;
        rd(8'h24, 16'h0226);
        finish_test();
    end
endmodule
`default_nettype wire
